// ===== test/abu_assertions.sv
// Purpose: port-level checks of the breakpoint unit
// Assumes: abu_top ports, one clock domain
// Notes: bound to every abu_top
`timescale 1ns/10ps
module abu_assertions
(
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              break_request,
  input wire logic              break_return,
  input wire logic              high_test_voltage,
  input wire abu_pkg::abu_ctl_t ctl
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  AST_HALT: assert property (break_request |-> ctl.halt_timers)
    else $error("no timer halt at break request");
  AST_HOLD: assert property (ctl.halt_timers && !break_return |=> ctl.halt_timers)
    else $error("timer halt dropped inside break");
  AST_ONE: assert property (break_request |=> !break_request)
    else $error("break request longer than one cycle");
  AST_ENTRY: assert property ($rose(ctl.halt_timers) |-> break_request)
    else $error("break entered without request");
  AST_WDOG: assert property (ctl.watchdog_off |-> ctl.halt_timers)
    else $error("watchdog off outside break");
  AST_WDON: assert property ((high_test_voltage [*7] ##0 ctl.halt_timers) |-> ctl.watchdog_off)
    else $error("watchdog running in break with test voltage");
  AST_CLR: assert property (!ctl.halt_timers |-> ctl.flag_clear_ok)
    else $error("flag clearing blocked outside break");
  AST_END: assert property (break_return && ctl.halt_timers |=> !ctl.halt_timers)
    else $error("break outlived return");
endmodule

bind abu_top abu_assertions u_chk
(
  .clk(clk), .reset(reset), .break_request(break_request), .break_return(break_return),
  .high_test_voltage(high_test_voltage), .ctl(ctl)
);

// ===== test/abu_cpu_model.sv
// Purpose: cpu and integration-logic stand-in
// Assumes: program counter steps once a cycle while not halted
// Notes: raises break_return RET_CYC + 1 cycles after break entry
`timescale 1ns/10ps
module abu_cpu_model
#(
  parameter int RET_CYC = 40
)
(
  input  wire logic           clk,
  input  wire logic           reset,
  input  wire logic           load,
  input  wire logic [15:0]    load_pc,
  input  wire logic           halt,
  output abu_pkg::abu_fetch_t fetch,
  output logic                instr_boundary,
  output logic                break_return
);
  logic [15:0] pc_q;
  int          wait_q;
  assign fetch = '{addr: pc_q, valid: !halt, opcode: 1'b1};
  assign instr_boundary = !halt;
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      pc_q <= 16'h0000;
      wait_q <= 0;
      break_return <= 1'b0;
    end
    else
    begin
      pc_q <= load ? load_pc : (halt ? pc_q : pc_q + 16'h0001);
      wait_q <= halt ? wait_q + 1 : 0;
      break_return <= halt && wait_q == RET_CYC;
    end
endmodule

// ===== test/address_breakpoint_unit_bench.sv
// Purpose: register and break-sequence tests of the breakpoint unit
// Assumes: zero-wait AHB-Lite slave, cpu stand-in model
// Notes: break pulses are counted in req_count
`timescale 1ns/10ps
module address_breakpoint_unit_bench;
  logic                clk = 0;
  logic                reset = 1;
  logic                hwrite = 0;
  logic                hreadyout, hresp, break_request, break_opcode, irq;
  logic                instr_boundary, break_return, load = 0;
  logic                wait_mode = 0;
  logic                op_seen = 0;
  logic                emulation_mode = 0;
  logic                high_test_voltage = 1;
  logic [1:0]          htrans = 0;
  logic [15:0]         load_pc = 0;
  logic [31:0]         haddr = 0;
  logic [31:0]         hwdata = 0;
  logic [31:0]         hrdata, rd;
  abu_pkg::abu_fetch_t fetch;
  abu_pkg::abu_ctl_t   ctl;
  int                  req_count = 0;
  int                  fail_count = 0;
  int                  comparisons = 0;
  always #10 clk = !clk;
  always @(posedge clk)
  begin
    if (break_request === 1'b1)
    begin
      req_count <= req_count + 1;
      op_seen   <= break_opcode;
    end
  end
  abu_top u_dut (.clk(clk), .reset(reset), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(abu_pkg::ABU_HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fetch(fetch),
    .instr_boundary(instr_boundary), .break_return(break_return), .wait_mode(wait_mode),
    .emulation_mode(emulation_mode), .high_test_voltage(high_test_voltage),
    .break_request(break_request), .break_opcode(break_opcode), .ctl(ctl), .irq(irq));
  abu_cpu_model u_cpu (.clk(clk), .reset(reset), .load(load), .load_pc(load_pc),
    .halt(ctl.halt_timers), .fetch(fetch), .instr_boundary(instr_boundary),
    .break_return(break_return));
  task automatic complete_run();
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      fail_count++;
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    htrans <= abu_pkg::ABU_HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    check(rd, exp);
    check(hresp, 32'h00000000);
  endtask
  task automatic wait_req(input int n);
    repeat (60) if (req_count != n) @(posedge clk);
    check(req_count, n);
  endtask
  task automatic end_break();
    repeat (80) if (ctl.halt_timers !== 1'b0) @(posedge clk);
    #1;
    check(ctl, 3'h1);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    reset <= 0;
    rdc(abu_pkg::ABU_OFS_CTRL, 32'h00000000);
    rdc(abu_pkg::ABU_OFS_ADDRH, 32'h00000000);
    rdc(abu_pkg::ABU_OFS_ADDRL, 32'h00000000);
    bus(1'b1, abu_pkg::ABU_OFS_ADDRH, 32'h00000012);
    bus(1'b1, abu_pkg::ABU_OFS_ADDRL, 32'h00000034);
    rdc(abu_pkg::ABU_OFS_ADDRH, 32'h00000012);
    rdc(abu_pkg::ABU_OFS_ADDRL, 32'h00000034);
    rdc(8'h1C, 32'h00000000);
    bus(1'b1, abu_pkg::ABU_OFS_IMASK, 32'h00000001);
    bus(1'b1, abu_pkg::ABU_OFS_CTRL, 32'h00000080);
    rdc(abu_pkg::ABU_OFS_CTRL, 32'h00000080);
    load <= 1;
    load_pc <= 16'h1230;
    @(posedge clk);
    load <= 0;
    wait_req(1);
    check(op_seen, 1);
    rdc(abu_pkg::ABU_OFS_CTRL, 32'h000000C0);
    #1;
    check(ctl, 3'h6);
    check(irq, 1);
    bus(1'b1, abu_pkg::ABU_OFS_FCLR, 32'h00000080);
    #1;
    check(ctl.flag_clear_ok, 1);
    bus(1'b1, abu_pkg::ABU_OFS_CTRL, 32'h00000080);
    rdc(abu_pkg::ABU_OFS_CTRL, 32'h00000080);
    bus(1'b1, abu_pkg::ABU_OFS_ISTAT, 32'h00000001);
    #1;
    check(irq, 0);
    end_break();
    bus(1'b1, abu_pkg::ABU_OFS_CTRL, 32'h00000000);
    rdc(abu_pkg::ABU_OFS_CTRL, 32'h00000000);
    load <= 1;
    @(posedge clk);
    load <= 0;
    repeat (20) @(posedge clk);
    check(req_count, 1);
    wait_mode <= 1;
    emulation_mode <= 1;
    bus(1'b1, abu_pkg::ABU_OFS_CTRL, 32'h00000040);
    wait_req(2);
    wait_mode <= 0;
    high_test_voltage <= 0;
    rdc(abu_pkg::ABU_OFS_WSTAT, 32'h00000002);
    rdc(abu_pkg::ABU_OFS_ISTAT, 32'h00000006);
    emulation_mode <= 0;
    #1;
    check(ctl, 3'h5);
    rdc(abu_pkg::ABU_OFS_WSTAT, 32'h00000000);
    bus(1'b1, abu_pkg::ABU_OFS_CTRL, 32'h00000000);
    end_break();
    complete_run();
  end
  initial
  begin
    #100000;
    fail_count++;
    complete_run();
  end
endmodule

// ===== verilog/abu_pkg.sv
// Purpose: constants and types for the address breakpoint unit
// Assumes: AHB-Lite register access, 32-bit words, one register per word
// Notes:
package abu_pkg;
  localparam logic [7:0] ABU_OFS_CTRL   = 8'h00;
  localparam logic [7:0] ABU_OFS_ADDRH  = 8'h04;
  localparam logic [7:0] ABU_OFS_ADDRL  = 8'h08;
  localparam logic [7:0] ABU_OFS_WSTAT  = 8'h0C;
  localparam logic [7:0] ABU_OFS_FCLR   = 8'h10;
  localparam logic [7:0] ABU_OFS_ISTAT  = 8'h14;
  localparam logic [7:0] ABU_OFS_IMASK  = 8'h18;

  localparam int ABU_BIT_ENABLE  = 7;
  localparam int ABU_BIT_ACTIVE  = 6;
  localparam int ABU_BIT_WEXIT   = 1;
  localparam int ABU_BIT_CLREN   = 7;
  localparam int ABU_BIT_EVMATCH = 0;
  localparam int ABU_BIT_EVSOFT  = 1;
  localparam int ABU_BIT_EVWAIT  = 2;

  localparam logic [7:0] ABU_RST_BYTE = 8'h00;
  localparam logic [2:0] ABU_RST_EV   = 3'h0;
  localparam int ABU_EV_W = 3;

  localparam logic [1:0] ABU_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] ABU_HSIZE_WORD    = 3'h2;

  typedef struct packed {
    logic [15:0] addr;
    logic        valid;
    logic        opcode;
  } abu_fetch_t;

  typedef struct packed {
    logic halt_timers;
    logic watchdog_off;
    logic flag_clear_ok;
  } abu_ctl_t;

  typedef enum logic [1:0] {ABU_IDLE, ABU_PEND, ABU_BREAK} abu_state_t;
endpackage

// ===== verilog/abu_sync3.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input from outside the clock domain
// Notes: output changes once stages two and three agree
`timescale 1ns/10ps
module abu_sync3
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic async_in,
  output logic      sync_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic out_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      out_q <= 1'b0;
    end
    else
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        out_q <= s3_q;
    end
  end

  assign sync_out = out_q;
endmodule

// ===== verilog/abu_top.sv
// Purpose: address breakpoint unit with AHB-Lite register slave
// Assumes: single clock, asynchronous active-high reset
// Notes: break request is a one-cycle pulse to the integration logic
`timescale 1ns/10ps
module abu_top
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic [31:0]           hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire abu_pkg::abu_fetch_t fetch,
  input  wire logic             instr_boundary,
  input  wire logic             break_return,
  input  wire logic             wait_mode,
  input  wire logic             emulation_mode,
  input  wire logic             high_test_voltage,
  output logic                  break_request,
  output logic                  break_opcode,
  output abu_pkg::abu_ctl_t     ctl,
  output logic                  irq
);
  logic [7:0]  addr_hi_q;
  logic [7:0]  addr_lo_q;
  logic        enable_q;
  logic        active_q;
  logic        clr_en_q;
  logic        wexit_q;
  logic [2:0]  ev_q;
  logic [2:0]  mask_q;
  logic        soft_pend_q;
  logic        req_q;
  logic        req_op_q;
  logic [15:0] prev_addr_q;
  logic        prev_valid_q;
  logic        wr_q;
  logic [7:0]  wofs_q;
  logic [31:0] rdata_q;
  abu_pkg::abu_state_t state_q;
  abu_pkg::abu_state_t state_d;

  logic htv_sync;

  abu_sync3 u_htv_sync
  (
    .clk      (clk),
    .reset    (reset),
    .async_in (high_test_voltage),
    .sync_out (htv_sync)
  );

  // bus decode
  wire        bus_go   = hsel && hready && (htrans == abu_pkg::ABU_HTRANS_NONSEQ);
  wire        wr_go    = bus_go && hwrite && (hsize == abu_pkg::ABU_HSIZE_WORD);
  wire        rd_go    = bus_go && !hwrite;
  wire [7:0]  aofs     = haddr[7:0];
  wire [7:0]  wbyte    = hwdata[7:0];
  wire        wr_ctrl  = wr_q && (wofs_q == abu_pkg::ABU_OFS_CTRL);
  wire        wr_hi    = wr_q && (wofs_q == abu_pkg::ABU_OFS_ADDRH);
  wire        wr_lo    = wr_q && (wofs_q == abu_pkg::ABU_OFS_ADDRL);
  wire        wr_fclr  = wr_q && (wofs_q == abu_pkg::ABU_OFS_FCLR);
  wire        wr_istat = wr_q && (wofs_q == abu_pkg::ABU_OFS_ISTAT);
  wire        wr_imask = wr_q && (wofs_q == abu_pkg::ABU_OFS_IMASK);

  // match detection, one pulse per new matching access
  wire [15:0] brk_addr  = {addr_hi_q, addr_lo_q};
  wire        new_acc   = fetch.valid && !(prev_valid_q && prev_addr_q == fetch.addr);
  wire        hit       = enable_q && fetch.valid && (fetch.addr == brk_addr);
  wire        match_ev  = hit && new_acc;
  wire        soft_set  = wr_ctrl && wbyte[abu_pkg::ABU_BIT_ACTIVE] && !active_q;
  wire        soft_go   = soft_pend_q && instr_boundary;
  wire        in_break  = (state_q == abu_pkg::ABU_BREAK);
  wire        wexit_ev  = (match_ev || soft_go) && wait_mode && emulation_mode;
  wire [2:0]  ev_new    = {wexit_ev, soft_set, match_ev};

  // break state sequencing
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      abu_pkg::ABU_IDLE:
        if (match_ev || soft_go)
          state_d = abu_pkg::ABU_BREAK;
        else if (soft_pend_q)
          state_d = abu_pkg::ABU_PEND;
      abu_pkg::ABU_PEND:
        if (soft_go)
          state_d = abu_pkg::ABU_BREAK;
      abu_pkg::ABU_BREAK:
        if (break_return)
          state_d = abu_pkg::ABU_IDLE;
      default:
        state_d = abu_pkg::ABU_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q      <= abu_pkg::ABU_IDLE;
      prev_addr_q  <= 16'h0000;
      prev_valid_q <= 1'b0;
      req_q        <= 1'b0;
      req_op_q     <= 1'b0;
      soft_pend_q  <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      prev_addr_q  <= fetch.addr;
      prev_valid_q <= fetch.valid;
      req_q        <= match_ev || soft_go;
      req_op_q     <= match_ev ? fetch.opcode : soft_go;
      soft_pend_q  <= soft_set || (soft_pend_q && !instr_boundary);
    end
  end

  // control, address and flag registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      enable_q  <= 1'b0;
      active_q  <= 1'b0;
      addr_hi_q <= abu_pkg::ABU_RST_BYTE;
      addr_lo_q <= abu_pkg::ABU_RST_BYTE;
      clr_en_q  <= 1'b0;
      wexit_q   <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        enable_q <= wbyte[abu_pkg::ABU_BIT_ENABLE];
      if (match_ev || soft_set)
        active_q <= 1'b1;
      else if (wr_ctrl && !wbyte[abu_pkg::ABU_BIT_ACTIVE])
        active_q <= 1'b0;
      if (wr_hi)
        addr_hi_q <= wbyte;
      if (wr_lo)
        addr_lo_q <= wbyte;
      if (wr_fclr)
        clr_en_q <= wbyte[abu_pkg::ABU_BIT_CLREN];
      if (wexit_ev)
        wexit_q <= 1'b1;
      else if (match_ev || soft_go)
        wexit_q <= 1'b0;
    end
  end

  // interrupt status and mask, set wins over write-one-to-clear
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ev_q   <= abu_pkg::ABU_RST_EV;
      mask_q <= abu_pkg::ABU_RST_EV;
    end
    else
    begin
      ev_q <= ev_new | (ev_q & ~(wr_istat ? hwdata[abu_pkg::ABU_EV_W-1:0] : 3'h0));
      if (wr_imask)
        mask_q <= hwdata[abu_pkg::ABU_EV_W-1:0];
    end
  end

  // read mux
  wire [7:0]  ctrl_rd  = {active_q ? 1'b1 : 1'b0, 7'h00} >> 1
                         | {enable_q, 7'h00};
  wire [7:0]  wstat_rd = emulation_mode ? {6'h00, wexit_q, 1'b0} : 8'h00;
  wire [7:0]  rd_byte  =
      (aofs == abu_pkg::ABU_OFS_CTRL)  ? ctrl_rd :
      (aofs == abu_pkg::ABU_OFS_ADDRH) ? addr_hi_q :
      (aofs == abu_pkg::ABU_OFS_ADDRL) ? addr_lo_q :
      (aofs == abu_pkg::ABU_OFS_WSTAT) ? wstat_rd :
      (aofs == abu_pkg::ABU_OFS_FCLR)  ? {clr_en_q, 7'h00} :
      (aofs == abu_pkg::ABU_OFS_ISTAT) ? {5'h00, ev_q} :
      (aofs == abu_pkg::ABU_OFS_IMASK) ? {5'h00, mask_q} : 8'h00;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wr_q    <= 1'b0;
      wofs_q  <= 8'h00;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      wr_q   <= wr_go;
      wofs_q <= aofs;
      if (rd_go)
        rdata_q <= {24'h000000, rd_byte};
    end
  end

  assign hrdata        = rdata_q;
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign break_request = req_q;
  assign break_opcode  = req_op_q;
  assign ctl.halt_timers   = in_break;
  assign ctl.watchdog_off  = in_break && htv_sync;
  assign ctl.flag_clear_ok = !in_break || clr_en_q;
  assign irq           = |(ev_q & mask_q);
endmodule
